// file: rtl/pulse_gen_pkg.sv
package pulse_gen_pkg;

  typedef enum logic [1:0] {
    PM_SINGLE = 2'h0,
    PM_DOUBLE = 2'h1,
    PM_TRAIN  = 2'h2
  } pulse_mode_type;

  typedef enum logic [2:0] {
    TM_AUTO       = 3'h0,
    TM_SINGLE     = 3'h1,
    TM_EXT_SINGLE = 3'h2,
    TM_EXT_TRIG   = 3'h3,
    TM_GATED      = 3'h4
  } trig_mode_type;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_LATENCY = 3'b001,
    ST_RUN     = 3'b011,
    ST_DELAY   = 3'b010,
    ST_TRAIN   = 3'b110
  } state_type;

endpackage

// file: rtl/pulse_gen_regs.svh
`ifndef PULSE_GEN_REGS_SVH
`define PULSE_GEN_REGS_SVH

// Register byte offsets.
`define PG_CTRL_OFS      8'h00
`define PG_CMD_OFS       8'h04
`define PG_PERIOD_OFS    8'h08
`define PG_WIDTH_OFS     8'h0C
`define PG_DELAY_OFS     8'h10
`define PG_DBL_DELAY_OFS 8'h14
`define PG_DBL_WIDTH_OFS 8'h18
`define PG_STATUS_OFS    8'h1C
`define PG_ROW_SEL_OFS   8'h20
`define PG_ROW_ON_OFS    8'h24
`define PG_ROW_OFF_OFS   8'h28
`define PG_ROW_CNT_OFS   8'h2C
`define PG_TRAIN_LEN_OFS 8'h30

// Control field positions.
`define PG_MODE_LSB      0
`define PG_TRIG_LSB      2
`define PG_OUT_EN_BIT    5
`define PG_OUT_POL_BIT   6
`define PG_TRIG_POL_BIT  7
`define PG_CMD_SINGLE    0

// Reset values.
`define PG_CTRL_RST      8'h00
`define PG_PERIOD_RST    32'h0000_000A
`define PG_WIDTH_RST     32'h0000_0002
`define PG_DELAY_RST     32'h0000_0000
`define PG_DBL_DELAY_RST 32'h0000_0004
`define PG_DBL_WIDTH_RST 32'h0000_0002

// Timing.
`define PG_CLK_NS        40
`define PG_MIN_GAP_NS    20
`define PG_MIN_GAP_CYC   ((`PG_MIN_GAP_NS + `PG_CLK_NS - 1) / `PG_CLK_NS)
`define PG_TRIG_LAT_CYC  2
`define PG_SYNC_CYC      1

`endif

// file: rtl/triggered_pulse_generator.sv
// Contract
// - Single mode emits exactly one pulse per period.
// - Double mode emits a first and a second pulse per period.
// - Train mode walks rows, replaying each on/off pair count times.
// - Train rows with zero count are skipped but kept.
// - Auto trigger mode generates continuously without trigger.
// - Internal single mode runs once per software command, then idles.
// - External single mode runs one period per external trigger taken while idle, then idles.
// - External triggered mode restarts on an active trigger edge, except during latency or a double pulse pair.
// - Gated mode repeats pulses only while the gate is active.
// - Normal trigger polarity makes the rising edge active.
// - Triggers arriving during a double pulse pair are ignored.
// - Sync starts a fixed latency after trigger, before the delayed pulse.
// - Outside double mode the pulse waits the programmed delay.
// - Double mode skips the delay; first pulse starts at once.
// - Second pulse starts double delay after first pulse start.
// - Second pulse lasts double width; first uses normal width.
// - Width must be at least 20 ns below period.
// - Period runs from one pulse start to the next.
// - Pulse output driven only while output enable is on.
// - Output polarity setting inverts or passes the pulse.
`include "pulse_gen_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module triggered_pulse_generator
  import pulse_gen_pkg::*;
#(
  parameter int CW   = 24,
  parameter int NW   = 16,
  parameter int ROWS = 16
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        TRIG_IN,
  output logic             SYNC_OUT,
  output logic             PULSE_OUT
);
  localparam int RW = $clog2(ROWS);

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a[1:0] == 2'h0) && (a <= `PG_TRAIN_LEN_OFS);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (s[i])
        merge[i*8 +: 8] = d[i*8 +: 8];
  endfunction

  logic [7:0]         aw_addr;
  logic               aw_hold;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;
  logic               w_hold;
  logic               do_wr;
  logic [7:0]         ctrl;
  logic [CW-1:0]      period;
  logic [CW-1:0]      width;
  logic [CW-1:0]      delay;
  logic [CW-1:0]      dbl_delay;
  logic [CW-1:0]      dbl_width;
  logic [RW-1:0]      row_sel;
  logic [RW:0]        train_len;
  logic [CW-1:0]      on_mem [ROWS];
  logic [CW-1:0]      off_mem [ROWS];
  logic [NW-1:0]      cnt_mem [ROWS];
  logic               single_cmd;
  logic [31:0]        rd_val;
  logic [2:0]         trig_sync;
  logic               trig_lvl;
  logic               trig_edge;
  logic               gate_act;
  state_type          state;
  logic [1:0]         lat_cnt;
  logic [CW-1:0]      t;
  pulse_mode_type     cur_mode;
  trig_mode_type      trig_mode;
  pulse_mode_type     act_mode;
  logic [CW-1:0]      act_period;
  logic [CW-1:0]      act_width;
  logic [CW-1:0]      act_delay;
  logic [CW-1:0]      act_ddelay;
  logic [CW-1:0]      act_dwidth;
  logic               cfg_ok;
  logic               period_end;
  logic               again;
  logic               go;
  logic               retrig;
  logic               gate_stop;
  logic               load_cfg;
  logic [RW:0]        row;
  logic               row_load;
  logic               ph_on;
  logic [NW-1:0]      rep;
  logic [CW-1:0]      tcnt;
  logic               train_done;
  logic               pulse;
  logic               sync;

  // Bus slave: address and data are taken independently, one write at a time.
  assign S_AXI_AWREADY = !aw_hold && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_hold && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign do_wr         = aw_hold && w_hold && !S_AXI_BVALID;

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      aw_hold      <= 1'b0;
      aw_addr      <= 8'h00;
      w_hold       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= 2'h0;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_hold <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_hold <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_wr)
      begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= addr_mapped(aw_addr) ? 2'h0 : 2'h2;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      ctrl      <= `PG_CTRL_RST;
      period    <= CW'(`PG_PERIOD_RST);
      width     <= CW'(`PG_WIDTH_RST);
      delay     <= CW'(`PG_DELAY_RST);
      dbl_delay <= CW'(`PG_DBL_DELAY_RST);
      dbl_width <= CW'(`PG_DBL_WIDTH_RST);
      row_sel   <= '0;
      train_len <= '0;
    end
    else if (do_wr)
    begin
      if (aw_addr == `PG_CTRL_OFS)
        ctrl <= 8'(merge({24'h00_0000, ctrl}, w_data, w_strb));
      else if (aw_addr == `PG_PERIOD_OFS)
        period <= CW'(merge(32'(period), w_data, w_strb));
      else if (aw_addr == `PG_WIDTH_OFS)
        width <= CW'(merge(32'(width), w_data, w_strb));
      else if (aw_addr == `PG_DELAY_OFS)
        delay <= CW'(merge(32'(delay), w_data, w_strb));
      else if (aw_addr == `PG_DBL_DELAY_OFS)
        dbl_delay <= CW'(merge(32'(dbl_delay), w_data, w_strb));
      else if (aw_addr == `PG_DBL_WIDTH_OFS)
        dbl_width <= CW'(merge(32'(dbl_width), w_data, w_strb));
      else if (aw_addr == `PG_ROW_SEL_OFS)
        row_sel <= RW'(merge(32'(row_sel), w_data, w_strb));
      else if (aw_addr == `PG_TRAIN_LEN_OFS)
        train_len <= (RW+1)'(merge(32'(train_len), w_data, w_strb));
    end
  end

  // The row table has no reset; software fills it before selecting train mode.
  always_ff @(posedge CORE_CLK)
  begin
    if (do_wr && aw_addr == `PG_ROW_ON_OFS)
      on_mem[row_sel] <= CW'(merge(32'(on_mem[row_sel]), w_data, w_strb));
    if (do_wr && aw_addr == `PG_ROW_OFF_OFS)
      off_mem[row_sel] <= CW'(merge(32'(off_mem[row_sel]), w_data, w_strb));
    if (do_wr && aw_addr == `PG_ROW_CNT_OFS)
      cnt_mem[row_sel] <= NW'(merge(32'(cnt_mem[row_sel]), w_data, w_strb));
  end

  assign single_cmd = do_wr && aw_addr == `PG_CMD_OFS && w_strb[0] && w_data[`PG_CMD_SINGLE];

  always_comb
  begin
    if (S_AXI_ARADDR == `PG_CTRL_OFS)
      rd_val = {24'h00_0000, ctrl};
    else if (S_AXI_ARADDR == `PG_PERIOD_OFS)
      rd_val = 32'(period);
    else if (S_AXI_ARADDR == `PG_WIDTH_OFS)
      rd_val = 32'(width);
    else if (S_AXI_ARADDR == `PG_DELAY_OFS)
      rd_val = 32'(delay);
    else if (S_AXI_ARADDR == `PG_DBL_DELAY_OFS)
      rd_val = 32'(dbl_delay);
    else if (S_AXI_ARADDR == `PG_DBL_WIDTH_OFS)
      rd_val = 32'(dbl_width);
    else if (S_AXI_ARADDR == `PG_STATUS_OFS)
      rd_val = {16'h0000, 8'(row), 3'(state), 3'h0, cfg_ok, state != ST_IDLE};
    else if (S_AXI_ARADDR == `PG_ROW_SEL_OFS)
      rd_val = 32'(row_sel);
    else if (S_AXI_ARADDR == `PG_ROW_ON_OFS)
      rd_val = 32'(on_mem[row_sel]);
    else if (S_AXI_ARADDR == `PG_ROW_OFF_OFS)
      rd_val = 32'(off_mem[row_sel]);
    else if (S_AXI_ARADDR == `PG_ROW_CNT_OFS)
      rd_val = 32'(cnt_mem[row_sel]);
    else if (S_AXI_ARADDR == `PG_TRAIN_LEN_OFS)
      rd_val = 32'(train_len);
    else
      rd_val = 32'h0000_0000;
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= 2'h0;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_val;
      S_AXI_RRESP  <= addr_mapped(S_AXI_ARADDR) ? 2'h0 : 2'h2;
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
      S_AXI_RVALID <= 1'b0;
  end

  // Trigger pin: two stages for metastability, a third only for the edge.
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      trig_sync <= 3'h0;
    else
      trig_sync <= {trig_sync[1:0], TRIG_IN};
  end

  assign trig_lvl  = trig_sync[1] ^ ctrl[`PG_TRIG_POL_BIT];
  assign trig_edge = trig_lvl && !(trig_sync[2] ^ ctrl[`PG_TRIG_POL_BIT]);
  assign gate_act  = trig_lvl;

  assign cur_mode  = (ctrl[1:0] == 2'h3) ? PM_SINGLE : pulse_mode_type'(ctrl[1:0]);
  assign trig_mode = (ctrl[4:2] > 3'h4) ? TM_AUTO : trig_mode_type'(ctrl[4:2]);

  assign cfg_ok     = ({1'b0, width} + (CW+1)'(`PG_MIN_GAP_CYC)) <= {1'b0, period};
  assign period_end = ({1'b0, t} + (CW+1)'(1)) >= {1'b0, act_period};
  assign again      = trig_mode == TM_AUTO || (trig_mode == TM_GATED && gate_act);
  assign gate_stop  = trig_mode == TM_GATED && !gate_act && state != ST_IDLE;
  assign go = state == ST_IDLE &&
              (trig_mode == TM_AUTO ||
               (trig_mode == TM_SINGLE && single_cmd) ||
               (trig_mode == TM_EXT_SINGLE && trig_edge) ||
               (trig_mode == TM_EXT_TRIG && trig_edge) ||
               (trig_mode == TM_GATED && gate_act));
  // A double pair in flight is never cut short by a new edge.
  assign retrig = trig_mode == TM_EXT_TRIG && trig_edge &&
                  (state == ST_RUN || state == ST_DELAY || state == ST_TRAIN) &&
                  !(state == ST_RUN && act_mode == PM_DOUBLE);
  assign train_done = state == ST_TRAIN && row_load && row >= train_len;
  assign load_cfg = !gate_stop && !retrig &&
                    ((state == ST_LATENCY && lat_cnt == 2'(`PG_TRIG_LAT_CYC - 1)) ||
                     (state == ST_RUN && period_end && again) ||
                     (train_done && again));

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      state   <= ST_IDLE;
      lat_cnt <= 2'h0;
      t       <= '0;
    end
    else if (gate_stop)
      state <= ST_IDLE;
    else if (retrig)
    begin
      state   <= ST_LATENCY;
      lat_cnt <= 2'h0;
    end
    else
    begin
      case (state)
        ST_IDLE:
          if (go)
          begin
            state   <= ST_LATENCY;
            lat_cnt <= 2'h0;
          end
        ST_LATENCY:
          if (load_cfg)
          begin
            t     <= '0;
            state <= (cur_mode == PM_TRAIN) ? ST_DELAY : ST_RUN;
          end
          else
            lat_cnt <= lat_cnt + 2'h1;
        ST_RUN:
          if (period_end)
          begin
            t     <= '0;
            state <= !again ? ST_IDLE : (cur_mode == PM_TRAIN) ? ST_DELAY : ST_RUN;
          end
          else
            t <= t + CW'(1);
        ST_DELAY:
          if (t >= act_delay)
            state <= ST_TRAIN;
          else
            t <= t + CW'(1);
        ST_TRAIN:
          if (train_done)
          begin
            t     <= '0;
            state <= !again ? ST_IDLE : (cur_mode == PM_TRAIN) ? ST_DELAY : ST_RUN;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Working copies change only at a period start; a bad width is refused.
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      act_mode   <= PM_SINGLE;
      act_period <= CW'(`PG_PERIOD_RST);
      act_width  <= CW'(`PG_WIDTH_RST);
      act_delay  <= CW'(`PG_DELAY_RST);
      act_ddelay <= CW'(`PG_DBL_DELAY_RST);
      act_dwidth <= CW'(`PG_DBL_WIDTH_RST);
    end
    else if (load_cfg)
    begin
      act_mode   <= cur_mode;
      act_delay  <= delay;
      act_ddelay <= dbl_delay;
      act_dwidth <= dbl_width;
      if (cfg_ok)
      begin
        act_period <= period;
        act_width  <= width;
      end
    end
  end

  // Train sequencer; on and off times of zero still last one cycle each.
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      row      <= '0;
      row_load <= 1'b1;
      ph_on    <= 1'b0;
      rep      <= '0;
      tcnt     <= '0;
    end
    else if (state != ST_TRAIN || retrig || gate_stop)
    begin
      row      <= '0;
      row_load <= 1'b1;
      ph_on    <= 1'b0;
    end
    else if (row_load)
    begin
      if (train_done)
        row <= '0;
      else if (cnt_mem[row[RW-1:0]] == '0)
        row <= row + (RW+1)'(1);
      else
      begin
        rep      <= cnt_mem[row[RW-1:0]];
        ph_on    <= 1'b1;
        tcnt     <= '0;
        row_load <= 1'b0;
      end
    end
    else if (ph_on)
    begin
      if (tcnt + CW'(1) >= on_mem[row[RW-1:0]])
      begin
        ph_on <= 1'b0;
        tcnt  <= '0;
      end
      else
        tcnt <= tcnt + CW'(1);
    end
    else if (tcnt + CW'(1) >= off_mem[row[RW-1:0]])
    begin
      tcnt <= '0;
      if (rep == NW'(1))
      begin
        row      <= row + (RW+1)'(1);
        row_load <= 1'b1;
      end
      else
      begin
        rep   <= rep - NW'(1);
        ph_on <= 1'b1;
      end
    end
    else
      tcnt <= tcnt + CW'(1);
  end

  always_comb
  begin
    pulse = 1'b0;
    if (state == ST_RUN && act_mode == PM_DOUBLE)
      pulse = t < act_width ||
              (t >= act_ddelay &&
               {1'b0, t} < {1'b0, act_ddelay} + {1'b0, act_dwidth});
    else if (state == ST_RUN)
      pulse = t >= act_delay &&
              {1'b0, t} < {1'b0, act_delay} + {1'b0, act_width};
    else if (state == ST_TRAIN)
      pulse = !row_load && ph_on;
  end

  assign sync = (state == ST_RUN || state == ST_DELAY) &&
                t < CW'(`PG_SYNC_CYC);

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      SYNC_OUT  <= 1'b0;
      PULSE_OUT <= 1'b0;
    end
    else
    begin
      SYNC_OUT  <= sync;
      PULSE_OUT <= ctrl[`PG_OUT_EN_BIT] && (pulse ^ ctrl[`PG_OUT_POL_BIT]);
    end
  end

  a_out_disabled: assert property (@(posedge CORE_CLK) disable iff (RST)
    !ctrl[`PG_OUT_EN_BIT] |=> !PULSE_OUT) else $error("Pulse output active while disabled.");
  a_idle_polarity: assert property (@(posedge CORE_CLK) disable iff (RST)
    ctrl[`PG_OUT_EN_BIT] && state == ST_IDLE |=> PULSE_OUT == $past(ctrl[`PG_OUT_POL_BIT]))
    else $error("Idle output level does not follow polarity.");
  a_double_locked: assert property (@(posedge CORE_CLK) disable iff (RST)
    state == ST_RUN && act_mode == PM_DOUBLE && trig_mode != TM_GATED && !period_end
    |=> state == ST_RUN) else $error("Double pair interrupted by a trigger.");
  a_sync_latency: assert property (@(posedge CORE_CLK) disable iff (RST)
    state == ST_LATENCY && lat_cnt == 2'h0 && trig_mode != TM_GATED
    |-> ##2 (state == ST_RUN || state == ST_DELAY) ##1 SYNC_OUT)
    else $error("Sync did not follow the trigger latency.");
  a_single_delay: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(pulse) && state == ST_RUN && act_mode == PM_SINGLE |-> t == act_delay)
    else $error("Single pulse did not start at the delay.");
  a_double_first: assert property (@(posedge CORE_CLK) disable iff (RST)
    state == ST_RUN && act_mode == PM_DOUBLE && t == '0 && act_width != '0 |-> pulse)
    else $error("First double pulse delayed.");
  a_second_start: assert property (@(posedge CORE_CLK) disable iff (RST)
    state == ST_RUN && act_mode == PM_DOUBLE && act_dwidth != '0 && t == act_ddelay |-> pulse)
    else $error("Second pulse missing at double delay.");
  a_period_restart: assert property (@(posedge CORE_CLK) disable iff (RST)
    state == ST_RUN && period_end && trig_mode == TM_AUTO && cur_mode != PM_TRAIN
    |=> state == ST_RUN && t == '0) else $error("Period did not restart.");
  a_gate_stop: assert property (@(posedge CORE_CLK) disable iff (RST)
    trig_mode == TM_GATED && !gate_act |=> state == ST_IDLE) else $error("Pulses outside gate.");
  a_zero_row: assert property (@(posedge CORE_CLK) disable iff (RST)
    state == ST_TRAIN && row_load && row < train_len && cnt_mem[row[RW-1:0]] == '0 && !retrig
    && !gate_stop |=> row_load && row == $past(row) + (RW+1)'(1)) else $error("Zero row not skipped.");
  a_cfg_refuse: assert property (@(posedge CORE_CLK) disable iff (RST)
    load_cfg && !cfg_ok |=> act_width == $past(act_width)) else $error("Bad width accepted.");
endmodule
`default_nettype wire

// file: tb/trig_source.sv
`timescale 1ns/1ns
`default_nettype none
module trig_source (
  input  wire logic clk,
  input  wire logic fire,
  input  wire logic gate,
  output logic      trig
);
  logic [2:0] hold   = 3'h0;
  logic       trig_q = 1'b0;
  // A fired edge stays high four cycles so the two-flop synchroniser cannot miss it.
  always_ff @(posedge clk)
    hold <= fire ? 3'h4 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
  always_ff @(posedge clk)
    trig_q <= gate | (hold != 3'h0);
  assign trig = trig_q;
endmodule
`default_nettype wire

// file: tb/triggered_pulse_generator_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "pulse_gen_regs.svh"
module triggered_pulse_generator_tb
  import pulse_gen_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, fire = 1'b0, gate = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, sync, pulse, trig;
  logic [1:0]  bresp, rresp;
  int          miscompares = 0, tests_run = 0, cyc = 0, hi, ri, sy, fp;
  int          ac [4] = '{32'h20, 32'h60, 32'h00, 32'h21};
  int          ah [4] = '{8, 32, 0, 16};
  int          ar [4] = '{4, 4, 0, 8};
  int          af [4] = '{0, 1, 0, 1};
  int          tc [3] = '{32'h28, 32'h2C, 32'h2D};
  int          tg [3] = '{8, 15, 6};
  int          ts [3] = '{1, 2, 1};
  int          th [3] = '{2, 4, 4};
  int          ra [9] = '{8'h30, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h20, 8'h24, 8'h28, 8'h2C};
  int          rv [9] = '{2, 0, 2, 3, 0, 1, 3, 2, 2};

  always #20 clk = ~clk;

  triggered_pulse_generator uut (
    .CORE_CLK(clk), .RST(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .TRIG_IN(trig), .SYNC_OUT(sync), .PULSE_OUT(pulse)
  );
  trig_source partner (.clk(clk), .fire(fire), .gate(gate), .trig(trig));

  task automatic conclude();
    $display("Counts: tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %0t %s got %0h expected %0h", $time, m, g, e);
    end
  endtask

  // Ready is sampled at the falling edge, where it is settled, and acted on at the next rise.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge clk);
      ta = awready & awvalid;
      tw = wready & wvalid;
      tb = bvalid;
      got = {30'h0, bresp};
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk(got, {30'h0, er}, "write response");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge clk);
      ta = arready & arvalid;
      tr = rvalid;
      got = rdata;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(got, e, "read data");
    chk({30'h0, rresp}, {30'h0, er}, "read response");
  endtask

  task automatic meas(input int n, input int g);
    logic pv;
    hi = 0;
    ri = 0;
    sy = 0;
    fp = -1;
    pv = pulse;
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk);
      fire = (g > 0) && (i == 0 || i == g);
      hi += (pulse === 1'b1);
      ri += (pulse === 1'b1 && pv !== 1'b1);
      if (sync === 1'b1 && fp < 0) fp = pulse;
      sy += (sync === 1'b1);
      pv = pulse;
    end
    fire = 1'b0;
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(`PG_PERIOD_OFS, 32'h0000_000A, 2'h0);
    rd(`PG_DBL_DELAY_OFS, 32'h0000_0004, 2'h0);
    rd(8'h40, 32'h0000_0000, 2'h2);
    wr(8'h40, 32'h0000_0000, 2'h2);
    wr(`PG_WIDTH_OFS, 32'h0000_000A, 2'h0);
    rd(`PG_WIDTH_OFS, 32'h0000_000A, 2'h0);
    wr(`PG_DELAY_OFS, 32'h0000_0003, 2'h0);
    for (int k = 0; k < 4; k++)
    begin
      wr(`PG_CTRL_OFS, ac[k], 2'h0);
      repeat (25) @(posedge clk);
      meas(40, 0);
      chk(hi, ah[k], "high cycles");
      chk(ri, ar[k], "pulse starts");
      chk(sy, 4, "sync count");
      chk(fp, af[k], "pulse at sync");
    end
    for (int k = 0; k < 3; k++)
    begin
      wr(`PG_CTRL_OFS, tc[k], 2'h0);
      repeat (25) @(posedge clk);
      meas(40, tg[k]);
      chk(sy, ts[k], "triggered syncs");
      chk(hi, th[k], "triggered high cycles");
    end
    wr(`PG_CTRL_OFS, 32'h0000_0024, 2'h0);
    repeat (25) @(posedge clk);
    wr(`PG_CMD_OFS, 32'h0000_0001, 2'h0);
    meas(40, 0);
    chk(sy, 1, "software single syncs");
    chk(hi, 2, "software single high cycles");
    for (int k = 0; k < 9; k++)
      wr(ra[k][7:0], rv[k], 2'h0);
    rd(`PG_ROW_ON_OFS, 32'h0000_0003, 2'h0);
    wr(`PG_CTRL_OFS, 32'h0000_0026, 2'h0);
    wr(`PG_CMD_OFS, 32'h0000_0001, 2'h0);
    meas(80, 0);
    chk(hi, 6, "train high cycles");
    chk(ri, 2, "train pulses");
    wr(`PG_CTRL_OFS, 32'h0000_0030, 2'h0);
    repeat (25) @(posedge clk);
    gate <= 1'b1;
    repeat (12) @(posedge clk);
    meas(30, 0);
    chk(sy, 3, "gated syncs");
    chk(hi, 6, "gated high cycles");
    gate <= 1'b0;
    repeat (8) @(posedge clk);
    meas(20, 0);
    chk(sy + hi, 0, "gate closed activity");
    conclude();
  end
endmodule
`default_nettype wire
